// ===== rtl/ucpc_pkg.sv
// constants and register layout for the dual serial channel pin control block
// Behaviour
// - With the interrupt-output mode bit set, the channel interrupt pin is driven and the paired output port pin is driven low.
// - With that bit clear, its reset default, the interrupt pin floats and the output port pin is driven high.
// - Each channel has an active-low transmitter ready output that shows whether its transmit holding register is free.
// - Each channel has an active-low receiver ready output that shows whether its receive holding register holds data.
// - With infrared select clear, signalling is standard and the transmit line is high during reset and while idle.
// - With infrared select set, transmit and receive pass through the infrared encoder and decoder and the transmit line idles low.
// - Request-to-send is an active-low output, used either for flow control or as a software-driven output.
// - A trigger-control bit selects half-duplex direction control, where request-to-send marks the transmitter as active.
// - Clear-to-send is an active-low input, read by software or, when an enhanced-feature bit is set, gating transmission.
// - Data-terminal-ready is an active-low software-controlled output.
// - Data-set-ready, carrier-detect and ring-indicator are active-low inputs read by software that do not affect transfers.
package ucpc_pkg;
  // byte offsets inside one channel window
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_MCTL = 5'h04;
  localparam logic [4:0] OFS_FEAT = 5'h08;
  localparam logic [4:0] OFS_TRIG = 5'h0c;
  localparam logic [4:0] OFS_MASK = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_MSR = 5'h18;
  localparam int ADDR_W = 7;
  localparam int CHAN_BIT = 6; // address bit that picks the channel
  localparam logic [1:0] UNUSED_ZERO = 2'h0;
  // modem control fields
  localparam int MCTL_DTR = 0;
  localparam int MCTL_RTS = 1;
  localparam int MCTL_IRQ_OUT = 3;
  localparam int MCTL_IR_SEL = 6;
  // enhanced feature and trigger control fields
  localparam int FEAT_AUTO_RTS = 6;
  localparam int FEAT_AUTO_CTS = 7;
  localparam int TRIG_RX_INV = 2;
  localparam int TRIG_RS485 = 3;
  // status bits: rx data, tx empty, modem input change
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
  localparam int ST_MODEM = 2;
  localparam int ST_W = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  // bit timing at 200 MHz clock
  localparam int CLK_MHZ = 200;
  localparam int BIT_NS = 80;
  localparam int BIT_CYCLES = (BIT_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] BIT_HALF = 8'(BIT_CYCLES / 2);
  localparam logic [7:0] IR_PULSE = 8'((BIT_CYCLES * 3) / 16);
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [2:0] DATA_LAST = 3'h7;
endpackage

// ===== rtl/ucpc_serial.sv
// one channel serial engine: shifter, receiver and infrared coding
`timescale 1ns/1ps
`default_nettype none
module ucpc_serial
  import ucpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ir_mode_in,
  input wire logic rx_invert_in,
  input wire logic tx_allow_in,
  input wire logic tx_full_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_take_out,
  output logic tx_busy_out,
  output logic serial_out,
  input wire logic serial_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out
);
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} ucpc_rx_e;
  logic [9:0] tx_shift;
  logic [3:0] tx_bits;
  logic [7:0] tx_tick;
  logic [7:0] ir_hold;
  logic [7:0] rx_tick;
  logic [2:0] rx_bits;
  logic [7:0] rx_shift;
  ucpc_rx_e rx_state;
  wire tx_end_bit = (tx_tick == BIT_LAST);
  wire tx_level = tx_busy_out ? tx_shift[0] : 1'b1;
  // encoder pulses only for zero bits, so idle and ones stay low
  wire ir_tx = tx_busy_out & ~tx_shift[0] & (tx_tick < IR_PULSE);
  wire ir_pulse = serial_in ^ rx_invert_in;
  wire ir_decoded = ~(ir_pulse | (ir_hold != 8'h00));
  wire rx_line = ir_mode_in ? ir_decoded : serial_in;
  wire rx_end_bit = (rx_tick == BIT_LAST);

  // load the shifter only when idle and the flow gate allows
  assign tx_busy_out = (tx_bits != 4'h0);
  assign tx_take_out = tx_full_in & tx_allow_in & ~tx_busy_out;

  // transmit shifter, lsb first with start and stop
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_shift <= 10'h3ff;
      tx_bits <= 4'h0;
      tx_tick <= 8'h00;
    end else if (tx_take_out) begin
      tx_shift <= {1'b1, tx_data_in, 1'b0};
      tx_bits <= FRAME_BITS;
      tx_tick <= 8'h00;
    end else if (tx_busy_out) begin
      tx_tick <= tx_end_bit ? 8'h00 : tx_tick + 8'h01;
      if (tx_end_bit) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bits <= tx_bits - 4'h1;
      end
    end
  end

  // line driver, registered to avoid glitches on the pin
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= ir_mode_in ? ir_tx : tx_level;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ir_hold <= 8'h00;
    end else if (ir_mode_in & ir_pulse) begin
      ir_hold <= BIT_LAST;
    end else if (ir_hold != 8'h00) begin
      ir_hold <= ir_hold - 8'h01;
    end
  end

  // receiver: mid-bit sampling, relies on the line idling high
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_state <= R_IDLE;
      rx_tick <= 8'h00;
      rx_bits <= 3'h0;
      rx_shift <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
    end else begin
      rx_valid_out <= 1'b0;
      rx_tick <= rx_tick + 8'h01;
      case (rx_state)
        R_IDLE: begin
          rx_tick <= 8'h00;
          // a low level marks a start bit
          if (!rx_line) begin
            rx_state <= R_START;
          end
        end
        R_START: begin
          if (rx_tick == BIT_HALF) begin
            rx_tick <= 8'h00;
            rx_bits <= 3'h0;
            rx_state <= rx_line ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rx_end_bit) begin
            rx_tick <= 8'h00;
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bits <= rx_bits + 3'h1;
            if (rx_bits == DATA_LAST) begin
              rx_state <= R_STOP;
            end
          end
        end
        R_STOP: begin
          if (rx_end_bit) begin
            rx_state <= R_IDLE;
            // framing errors are dropped silently
            if (rx_line) begin
              rx_valid_out <= 1'b1;
              rx_data_out <= rx_shift;
            end
          end
        end
        default: rx_state <= R_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ucpc_top.sv
// two serial channels with pin control, modem lines and a register slave
`timescale 1ns/1ps
`default_nettype none
module ucpc_top
  import ucpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  output logic chan_a_irq_out,
  output logic chan_a_irq_oe_out,
  output logic chan_a_output_port_two_n_out,
  output logic chan_b_irq_out,
  output logic chan_b_irq_oe_out,
  output logic chan_b_output_port_two_n_out,
  output logic chan_a_tx_ready_n_out,
  output logic chan_a_rx_ready_n_out,
  output logic chan_b_tx_ready_n_out,
  output logic chan_b_rx_ready_n_out,
  output logic chan_a_serial_out,
  input wire logic chan_a_serial_in,
  output logic chan_b_serial_out,
  input wire logic chan_b_serial_in,
  output logic chan_a_request_to_send_n_out,
  input wire logic chan_a_clear_to_send_n_in,
  output logic chan_a_terminal_ready_n_out,
  input wire logic chan_a_set_ready_n_in,
  input wire logic chan_a_carrier_detect_n_in,
  input wire logic chan_a_ring_indicator_n_in,
  output logic chan_b_request_to_send_n_out,
  input wire logic chan_b_clear_to_send_n_in,
  output logic chan_b_terminal_ready_n_out,
  input wire logic chan_b_set_ready_n_in,
  input wire logic chan_b_carrier_detect_n_in,
  input wire logic chan_b_ring_indicator_n_in
);
  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // per-channel state, index 0 is channel a
  logic [7:0] modem_control_reg [2];
  logic [7:0] enhanced_feature_reg [2];
  logic [7:0] trigger_control_reg [2];
  logic [ST_W-1:0] interrupt_enable_reg [2];
  logic [ST_W-1:0] int_status [2];
  logic [7:0] transmit_holding_reg [2];
  logic [7:0] receive_holding_reg [2];
  logic tx_full [2];
  logic rx_full [2];
  logic [3:0] modem_prev [2];
  logic ack;

  // pin bundles gathered into arrays
  wire [3:0] modem_in [2];
  wire serial_in [2];
  wire cts_n [2];
  wire tx_take [2];
  wire tx_busy [2];
  wire serial_line [2];
  wire rx_valid [2];
  wire [7:0] rx_data [2];
  wire [1:0] chan_irq;
  wire [1:0] rts_n;
  // active-high view: ri, cd, dsr, cts
  assign modem_in[0] = ~{chan_a_ring_indicator_n_in, chan_a_carrier_detect_n_in,
                         chan_a_set_ready_n_in, chan_a_clear_to_send_n_in};
  assign modem_in[1] = ~{chan_b_ring_indicator_n_in, chan_b_carrier_detect_n_in,
                         chan_b_set_ready_n_in, chan_b_clear_to_send_n_in};
  assign serial_in[0] = chan_a_serial_in;
  assign serial_in[1] = chan_b_serial_in;
  assign cts_n[0] = chan_a_clear_to_send_n_in;
  assign cts_n[1] = chan_b_clear_to_send_n_in;

  // bus decode: one wait cycle, then the answer
  wire req = avs_read_in | avs_write_in;
  wire chan_sel = avs_address_in[CHAN_BIT];
  wire [4:0] ofs = avs_address_in[4:0];
  wire in_window = (avs_address_in[5] == 1'b0);
  wire wr_go = avs_write_in & ack & in_window & avs_byteenable_in[0];
  wire rd_go = avs_read_in & ack & in_window;
  wire [7:0] wbyte = avs_writedata_in[7:0];
  assign avs_waitrequest_out = req & ~ack;

  // does this access hit a given channel and offset
  function automatic logic hit(input logic go, input logic sel, input int ch,
                               input logic [4:0] o, input logic [4:0] want);
    hit = go & (sel == ch[0]) & (o == want);
  endfunction

  // read mux for one channel
  function automatic logic [7:0] chan_read(input int ch, input logic [4:0] o);
    chan_read = 8'h00;
    if (o == OFS_DATA) begin
      chan_read = receive_holding_reg[ch];
    end else if (o == OFS_MCTL) begin
      chan_read = modem_control_reg[ch];
    end else if (o == OFS_FEAT) begin
      chan_read = enhanced_feature_reg[ch];
    end else if (o == OFS_TRIG) begin
      chan_read = trigger_control_reg[ch];
    end else if (o == OFS_MASK) begin
      chan_read = {5'h00, interrupt_enable_reg[ch]};
    end else if (o == OFS_STAT) begin
      chan_read = {5'h00, int_status[ch]};
    end else if (o == OFS_MSR) begin
      chan_read = {UNUSED_ZERO, tx_busy[ch], tx_full[ch], modem_in[ch]};
    end
  endfunction

  wire [7:0] rd_byte = in_window ? chan_read(int'(chan_sel), ofs) : 8'h00;

  // read data captured in the wait cycle, stable at the answer edge
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      avs_readdata_out <= 32'h0;
    end else begin
      ack <= req & ~ack;
      if (avs_read_in & ~ack) begin
        avs_readdata_out <= {24'h0, rd_byte};
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      wire [7:0] mctl = modem_control_reg[ch];
      wire [7:0] feat = enhanced_feature_reg[ch];
      wire [7:0] trig = trigger_control_reg[ch];
      wire wr_data = hit(wr_go, chan_sel, ch, ofs, OFS_DATA);
      wire rd_data = hit(rd_go, chan_sel, ch, ofs, OFS_DATA);
      wire rd_stat = hit(rd_go, chan_sel, ch, ofs, OFS_STAT);
      wire modem_change = (modem_in[ch] != modem_prev[ch]);
      wire [ST_W-1:0] ev = {modem_change, tx_take[ch], rx_valid[ch]};
      // auto gate holds transmission while clear-to-send is off
      wire tx_allow = ~feat[FEAT_AUTO_CTS] | ~cts_n[ch];

      // control registers written by software, independent per channel
      always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
          modem_control_reg[ch] <= REG_RESET;
          enhanced_feature_reg[ch] <= REG_RESET;
          trigger_control_reg[ch] <= REG_RESET;
          interrupt_enable_reg[ch] <= ST_W'(REG_RESET);
        end else begin
          if (hit(wr_go, chan_sel, ch, ofs, OFS_MCTL)) begin
            modem_control_reg[ch] <= wbyte;
          end
          if (hit(wr_go, chan_sel, ch, ofs, OFS_FEAT)) begin
            enhanced_feature_reg[ch] <= wbyte;
          end
          if (hit(wr_go, chan_sel, ch, ofs, OFS_TRIG)) begin
            trigger_control_reg[ch] <= wbyte;
          end
          if (hit(wr_go, chan_sel, ch, ofs, OFS_MASK)) begin
            interrupt_enable_reg[ch] <= wbyte[ST_W-1:0];
          end
        end
      end

      // holding registers; a write while full is dropped
      always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
          transmit_holding_reg[ch] <= REG_RESET;
          receive_holding_reg[ch] <= REG_RESET;
          tx_full[ch] <= 1'b0;
          rx_full[ch] <= 1'b0;
        end else begin
          if (wr_data & ~tx_full[ch]) begin
            transmit_holding_reg[ch] <= wbyte;
            tx_full[ch] <= 1'b1;
          end else if (tx_take[ch]) begin
            tx_full[ch] <= 1'b0;
          end
          // new byte wins over a read in the same cycle; overrun overwrites
          if (rx_valid[ch]) begin
            receive_holding_reg[ch] <= rx_data[ch];
            rx_full[ch] <= 1'b1;
          end else if (rd_data) begin
            rx_full[ch] <= 1'b0;
          end
        end
      end

      // sticky status, read clears, set wins over the clear
      always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
          int_status[ch] <= ST_W'(REG_RESET);
          modem_prev[ch] <= 4'h0;
        end else begin
          modem_prev[ch] <= modem_in[ch];
          int_status[ch] <= (rd_stat ? ST_W'(REG_RESET) : int_status[ch]) | ev;
        end
      end

      assign chan_irq[ch] = |(int_status[ch] & interrupt_enable_reg[ch]);

      // request-to-send source selection
      // half-duplex: asserted while a byte waits or is sent
      // auto mode also needs the software bit set
      assign rts_n[ch] = trig[TRIG_RS485] ? ~(tx_busy[ch] | tx_full[ch]) :
                         feat[FEAT_AUTO_RTS] ? ~(mctl[MCTL_RTS] & ~rx_full[ch]) :
                         ~mctl[MCTL_RTS];

      ucpc_serial u_serial (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .ir_mode_in(mctl[MCTL_IR_SEL]),
        .rx_invert_in(trig[TRIG_RX_INV]),
        .tx_allow_in(tx_allow),
        .tx_full_in(tx_full[ch]),
        .tx_data_in(transmit_holding_reg[ch]),
        .tx_take_out(tx_take[ch]),
        .tx_busy_out(tx_busy[ch]),
        .serial_out(serial_line[ch]),
        .serial_in(serial_in[ch]),
        .rx_valid_out(rx_valid[ch]),
        .rx_data_out(rx_data[ch])
      );
    end
  endgenerate

  // system interrupt: any unmasked bit of either channel
  assign irq_out = |chan_irq;

  // mode bit drives pin or floats it, port pin opposite
  assign chan_a_irq_out = chan_irq[0];
  assign chan_a_irq_oe_out = modem_control_reg[0][MCTL_IRQ_OUT];
  assign chan_a_output_port_two_n_out = ~modem_control_reg[0][MCTL_IRQ_OUT];
  assign chan_b_irq_out = chan_irq[1];
  assign chan_b_irq_oe_out = modem_control_reg[1][MCTL_IRQ_OUT];
  assign chan_b_output_port_two_n_out = ~modem_control_reg[1][MCTL_IRQ_OUT];

  // ready pins low when space or data is there
  assign chan_a_tx_ready_n_out = tx_full[0];
  assign chan_a_rx_ready_n_out = ~rx_full[0];
  assign chan_b_tx_ready_n_out = tx_full[1];
  assign chan_b_rx_ready_n_out = ~rx_full[1];

  // serial and modem output pins
  assign chan_a_serial_out = serial_line[0];
  assign chan_b_serial_out = serial_line[1];
  assign chan_a_request_to_send_n_out = rts_n[0];
  assign chan_b_request_to_send_n_out = rts_n[1];
  assign chan_a_terminal_ready_n_out = ~modem_control_reg[0][MCTL_DTR];
  assign chan_b_terminal_ready_n_out = ~modem_control_reg[1][MCTL_DTR];
endmodule
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the dual channel pin control top
`timescale 1ns/1ps
`default_nettype none
module tb
  import ucpc_pkg::*;
;
  logic mclk_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
  logic [ADDR_W-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  logic chan_a_irq_out, chan_a_irq_oe_out, chan_a_output_port_two_n_out;
  logic chan_b_irq_out, chan_b_irq_oe_out, chan_b_output_port_two_n_out;
  logic chan_a_tx_ready_n_out, chan_a_rx_ready_n_out, chan_b_tx_ready_n_out, chan_b_rx_ready_n_out;
  logic chan_a_serial_out, chan_a_serial_in, chan_b_serial_out, chan_b_serial_in;
  logic chan_a_request_to_send_n_out, chan_a_clear_to_send_n_in, chan_a_terminal_ready_n_out;
  logic chan_b_request_to_send_n_out, chan_b_clear_to_send_n_in, chan_b_terminal_ready_n_out;
  logic chan_a_set_ready_n_in, chan_a_carrier_detect_n_in, chan_a_ring_indicator_n_in;
  logic chan_b_set_ready_n_in, chan_b_carrier_detect_n_in, chan_b_ring_indicator_n_in;
  logic [1:0] listen, stb;
  logic [7:0] got [2];
  logic [7:0] v, r;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  logic [7:0] ser_q[2][$];
  int miscompares = 0;
  int num_checks = 0;
  wire logic [1:0] oe = {chan_b_irq_oe_out, chan_a_irq_oe_out};
  wire logic [1:0] p2n = {chan_b_output_port_two_n_out, chan_a_output_port_two_n_out};
  wire logic [1:0] dtr = {chan_b_terminal_ready_n_out, chan_a_terminal_ready_n_out};
  wire logic [1:0] rts = {chan_b_request_to_send_n_out, chan_a_request_to_send_n_out};
  wire logic [1:0] txo = {chan_b_serial_out, chan_a_serial_out};
  wire logic [1:0] txr = {chan_b_tx_ready_n_out, chan_a_tx_ready_n_out};
  wire logic [1:0] rxr = {chan_b_rx_ready_n_out, chan_a_rx_ready_n_out};
  wire logic [1:0] irqv = {chan_b_irq_out, chan_a_irq_out};

  ucpc_top dut (.*);
  ucpc_peer peer_a (.mclk_in(mclk_in), .listen_in(listen[0]), .line_in(chan_a_serial_out),
    .line_out(chan_a_serial_in), .got_out(got[0]), .got_stb_out(stb[0]));
  ucpc_peer peer_b (.mclk_in(mclk_in), .listen_in(listen[1]), .line_in(chan_b_serial_out),
    .line_out(chan_b_serial_in), .got_out(got[1]), .got_stb_out(stb[1]));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic [6:0] a, input logic w, input logic [7:0] d);
    int n;
    begin
      n = 0;
      @(posedge mclk_in);
      avs_address_in <= a;
      avs_writedata_in <= {24'h0, d};
      avs_write_in <= w;
      avs_read_in <= !w;
      @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0 && n < 50) begin
        n++;
        @(posedge mclk_in);
      end
      if (n == 50) miscompares++;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // outputs watched at the edge; oldest note taken per result
  always @(posedge mclk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
      cmp(avs_readdata_out[7:0], exp_q.pop_front());
    for (int c = 0; c < 2; c++)
      if (stb[c] === 1'b1) cmp(got[c], ser_q[c].pop_front());
  end

  // hang guard; run needs well under 10000 cycles
  initial begin
    #200000;
    miscompares++;
    end_sim;
  end

  initial begin
    seed = 32'ha0ce1c12;
    {reset_n_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
    avs_byteenable_in = 4'hf;
    // peers deaf while mode bits flip the idle level of the lines
    listen = 2'b00;
    chan_a_clear_to_send_n_in = 1'b1;
    chan_b_clear_to_send_n_in = 1'($random(seed));
    {chan_a_set_ready_n_in, chan_a_carrier_detect_n_in, chan_a_ring_indicator_n_in} = 3'($random(seed));
    {chan_b_set_ready_n_in, chan_b_carrier_detect_n_in, chan_b_ring_indicator_n_in} = 3'($random(seed));
    wt(4);
    cmp({oe, p2n, txo, dtr}, 8'h3f);
    cmp({rts, txr, rxr, 2'b00}, 8'hcc);
    reset_n_in <= 1'b1;
    wt(2);
    // mode bits per channel with the other channel left cleared
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed)) & 8'h4b;
      bus({i[0], 1'b0, OFS_MCTL}, 1'b1, v);
      rd({i[0], 1'b0, OFS_MCTL}, v);
      wt(2);
      cmp({oe[i[0]], p2n[i[0]], dtr[i[0]], rts[i[0]], txo[i[0]], oe[!i[0]]},
        {v[3], !v[3], !v[0], !v[1], !v[6], 1'b0});
      bus({i[0], 1'b0, OFS_MCTL}, 1'b1, 8'h00);
    end
    bus(7'h24, 1'b1, 8'hff);
    rd(7'h20, 8'h00);
    rd({2'b00, OFS_MCTL}, 8'h00);
    listen <= 2'b11;
    // half duplex direction plus clear-to-send gating on channel a
    bus({2'b00, OFS_TRIG}, 1'b1, 8'h08);
    bus({2'b00, OFS_FEAT}, 1'b1, 8'h80);
    for (int k = 0; k < 2; k++) begin
      v = 8'($random(seed));
      ser_q[0].push_back(v);
      bus({2'b00, OFS_DATA}, 1'b1, v);
      wt(k == 0 ? 60 : 2);
      // second byte: the first one is already in its start bit
      cmp({txr[0], rts[0], txo[0]}, {2'b10, k == 0});
      r = {4'h1, !chan_a_ring_indicator_n_in, !chan_a_carrier_detect_n_in, !chan_a_set_ready_n_in, 1'b0};
      if (k == 0) rd({2'b00, OFS_MSR}, r);
      chan_a_clear_to_send_n_in <= 1'b0;
      wt(4);
    end
    for (int n = 0; n < 800 && ser_q[0].size() > 0; n++) wt(1);
    wt(20);
    cmp({txr[0], rts[0], txo[0], irq_out}, 4'b0110);
    // receive on a standard, on b infrared inverted; interrupt, mask, clear
    listen[1] <= 1'b0;
    // b status also holds the modem change seen after reset if a pin sat low
    r = {5'h00, ~&{chan_b_ring_indicator_n_in, chan_b_carrier_detect_n_in,
      chan_b_set_ready_n_in, chan_b_clear_to_send_n_in}, 2'b01};
    for (int c = 0; c < 2; c++) begin
      bus({c[0], 1'b0, OFS_MASK}, 1'b1, 8'h01);
      // a: software request bit first, then automatic request-to-send
      if (c == 0) bus({2'b00, OFS_TRIG}, 1'b1, 8'h00);
      if (c == 0) bus({2'b00, OFS_MCTL}, 1'b1, 8'h02);
      if (c == 0) bus({2'b00, OFS_FEAT}, 1'b1, 8'h40);
      // b: inversion before infrared, else the idle-high line reads as a pulse
      if (c == 1) bus({2'b10, OFS_TRIG}, 1'b1, 8'h04);
      if (c == 1) bus({2'b10, OFS_MCTL}, 1'b1, 8'h40);
      v = 8'($random(seed));
      if (c == 0) peer_a.send(v, 1'b0);
      else peer_b.send(v, 1'b1);
      wt(40);
      cmp({rxr[c], irq_out, irqv[c], rts[c]}, 4'b0111);
      rd({c[0], 1'b0, OFS_DATA}, v);
      rd({c[0], 1'b0, OFS_STAT}, c == 0 ? 8'h07 : r);
      wt(2);
      cmp({rxr[c], irq_out, rts[c]}, {2'b10, c[0]});
    end
    bus({2'b10, OFS_MCTL}, 1'b1, 8'h00);
    bus({2'b10, OFS_TRIG}, 1'b1, 8'h00);
    wt(40);
    listen[1] <= 1'b1;
    v = 8'($random(seed));
    ser_q[1].push_back(v);
    bus({2'b10, OFS_DATA}, 1'b1, v);
    for (int n = 0; n < 400 && ser_q[1].size() > 0; n++) wt(1);
    wt(20);
    cmp({exp_q.size() == 0, ser_q[1].size() == 0}, 2'b11);
    end_sim;
  end
endmodule
`default_nettype wire

// ===== verification/ucpc_chk.sv
// assertion checker for the dual channel pin control top
`timescale 1ns/1ps
`default_nettype none
module ucpc_chk
  import ucpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic irq_out,
  input wire logic chan_a_irq_out,
  input wire logic chan_a_irq_oe_out,
  input wire logic chan_a_output_port_two_n_out,
  input wire logic chan_b_irq_out,
  input wire logic chan_b_irq_oe_out,
  input wire logic chan_b_output_port_two_n_out,
  input wire logic chan_a_tx_ready_n_out,
  input wire logic chan_a_rx_ready_n_out,
  input wire logic chan_b_tx_ready_n_out,
  input wire logic chan_b_rx_ready_n_out
);
  logic wr_a, wr_b, rd_a, rd_b;
  // completed data accesses per channel
  assign wr_a = avs_write_in && !avs_waitrequest_out && avs_address_in == {2'b00, OFS_DATA};
  assign wr_b = avs_write_in && !avs_waitrequest_out && avs_address_in == {2'b10, OFS_DATA};
  assign rd_a = avs_read_in && !avs_waitrequest_out && avs_address_in == {2'b00, OFS_DATA};
  assign rd_b = avs_read_in && !avs_waitrequest_out && avs_address_in == {2'b10, OFS_DATA};
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_irq_pin_a: assert property (chan_a_irq_oe_out == !chan_a_output_port_two_n_out)
    else $error("channel a irq drive and port two disagree");
  a_irq_pin_b: assert property (chan_b_irq_oe_out == !chan_b_output_port_two_n_out)
    else $error("channel b irq drive and port two disagree");
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus access took more than one wait cycle");
  a_wait_idle: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("wait raised with no request");
  a_irq_merge: assert property (irq_out == (chan_a_irq_out || chan_b_irq_out))
    else $error("device irq is not the channel merge");
  a_tx_full_a: assert property ($rose(chan_a_tx_ready_n_out) |-> $past(wr_a))
    else $error("channel a tx ready dropped without a data write");
  a_tx_full_b: assert property ($rose(chan_b_tx_ready_n_out) |-> $past(wr_b))
    else $error("channel b tx ready dropped without a data write");
  a_rx_empty_a: assert property ($rose(chan_a_rx_ready_n_out) |-> $past(rd_a))
    else $error("channel a rx ready cleared without a data read");
  a_rx_empty_b: assert property ($rose(chan_b_rx_ready_n_out) |-> $past(rd_b))
    else $error("channel b rx ready cleared without a data read");
  c_irq: cover property ($rose(irq_out));
  c_rx_b: cover property ($fell(chan_b_rx_ready_n_out));
  c_tx_a: cover property ($rose(chan_a_tx_ready_n_out));
endmodule
bind ucpc_top ucpc_chk u_chk (.*);
`default_nettype wire

// ===== verification/ucpc_peer.sv
// remote serial peer: frame sender and standard receiver
`timescale 1ns/1ps
`default_nettype none
module ucpc_peer
  import ucpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic listen_in,
  input wire logic line_in,
  output logic line_out,
  output logic [7:0] got_out,
  output logic got_stb_out
);
  initial begin
    line_out = 1'b1;
    got_stb_out = 1'b0;
    got_out = 8'h00;
  end
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] fr;
    begin
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
        for (int k = 0; k < BIT_CYCLES; k++) begin
          @(posedge mclk_in);
          line_out <= ir ? !(!fr[i] && k < int'(IR_PULSE)) : fr[i];
        end
      end
    end
  endtask
  // mid-bit sampling; stop bit must be high
  initial begin
    forever begin
      @(negedge line_in iff listen_in);
      repeat (BIT_CYCLES / 2) @(posedge mclk_in);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES) @(posedge mclk_in);
        if (i < 8) got_out[i] <= line_in;
      end
      got_stb_out <= line_in;
      @(posedge mclk_in);
      got_stb_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire
